// [core/dti_pkg.sv]
// Constants and state layout for the trip decision and intertrip block.
package dti_pkg;
   // Clock and sampling timing.
   localparam int CLK_NS = 100;
   localparam int SAMPLES_PER_CYCLE = 8;
   localparam int HALF_CYCLE_SAMPLES = SAMPLES_PER_CYCLE / 2;
   localparam int SAMPLE_NS = 2500000;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
   localparam logic [2:0] LAST_PHASE = 3'(SAMPLES_PER_CYCLE - 1);
   // Trip decision: fault detection, then further samples to decide.
   localparam logic [2:0] TRIP_SAMPLES = 3'h4;
   localparam logic [2:0] EXTRA_SAMPLES = 3'h2;
   localparam logic [2:0] DETECT_SAMPLES = TRIP_SAMPLES - EXTRA_SAMPLES;
   // Numeric scale: doubled converter data, one per unit is 136 counts.
   localparam int ADC_W = 12;
   localparam int DATA_W = 13;
   localparam logic [DATA_W-1:0] PU_LSB = 13'h0088;
   localparam logic [DATA_W-1:0] PICKUP_LSB = PU_LSB / 13'h0005;
   localparam int BIAS_CUT_SHIFT = 2;
   // Message link: 21 bytes at 64 kbit/s.
   localparam int MSG_BYTES = 21;
   localparam int LINE_BPS = 64000;
   localparam int MSG_TIME_NS = 2700000;
   // Kept inside 32 bits: eight bit times in microseconds, scaled to nanoseconds.
   localparam int BYTE_NS = ((8 * 1000000) / (LINE_BPS / 1000));
   localparam int BYTE_CYC = BYTE_NS / CLK_NS;
   localparam logic [4:0] LAST_BYTE = 5'(MSG_BYTES - 1);
   localparam logic [4:0] CMD_BYTE = 5'h01;
   localparam logic [7:0] ITT_MASK = 8'h01;
   // Arrival registration latency bound.
   localparam int ARRIVAL_MAX_NS = 200000;
   localparam int ARRIVAL_MAX_CYC = ARRIVAL_MAX_NS / CLK_NS;

   // Whole state of the block.
   typedef struct packed {
      logic [15:0] samp_cnt;
      logic [2:0] phase;
      logic tick;
      logic [DATA_W-1:0] scaled;
      logic [2:0] op_cnt;
      logic detect;
      logic trip;
      logic rx_prev;
      logic rx_seen;
      logic rem_acc;
      logic [18:0] stamp;
      logic arr_v;
      logic calc_go;
      logic [4:0] byte_idx;
      logic head_v;
      logic [7:0] head_d;
      logic skid_v;
      logic [7:0] skid_d;
      logic [10:0] gap;
      logic out_v;
      logic in_rdy;
   } dti_state_s;

   localparam dti_state_s STATE_RESET = '0;
endpackage : dti_pkg

// [core/dti_core.sv]
// Trip decision, restraint hysteresis and intertrip send/receive logic.
`timescale 1ns/100ps

// The sample tick is made here from the clock, eight ticks per power cycle, so every
// sample side input is read only on a tick edge and may change freely in between.
// Trip follows a count of consecutive operate samples; a single quiet sample clears the
// count, which keeps isolated random errors from reaching the trip output.
// The restraint cut on trip widens the operate region, so a marginal fault does not hunt
// between trip and reset from one sample to the next.
// A received intertrip command needs two agreeing messages both to set and to clear, and
// it holds the trip state for as long as it stands accepted.
// Limitation: the message byte position counts from reset, so the framer must start its
// first message right after reset and never drop a byte.
// Outgoing bytes pass a two entry buffer and leave one per line byte time, so a stalled
// channel backs up into the framer instead of losing a byte.
module dti_core import dti_pkg::*; #(
   parameter logic [15:0] SAMPLE_PERIOD = 16'(SAMPLE_CYC),
   parameter logic [10:0] BYTE_PERIOD = 11'(BYTE_CYC)
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Sample inputs from the converter and the magnitude calculation.
   input wire logic [ADC_W-1:0] adc_data,
   input wire logic [DATA_W-1:0] diff_mag,
   input wire logic [DATA_W-1:0] bias_mag,
   // Sample side outputs.
   output logic sample_tick,
   output logic [DATA_W-1:0] scaled_sample,
   output logic fault_detect,
   output logic trip_out,
   // Received message events.
   input wire logic rx_msg_valid,
   input wire logic rx_itt,
   output logic rem_itt_accepted,
   output logic arrival_valid,
   output logic [18:0] arrival_stamp,
   output logic calc_start,
   // Outgoing message bytes from the framer.
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // Paced bytes toward the channel.
   output logic link_valid,
   output logic [7:0] link_data,
   input wire logic link_ready
);

   dti_state_s s_ff;
   dti_state_s nxt_s;
   logic [DATA_W-1:0] bias_eff;
   logic op_now;
   logic push;
   logic pop;
   logic [7:0] tx_byte;

   // Restraint with hysteresis and the operating comparison.
   always_comb begin
      bias_eff = bias_mag;
      if (s_ff.trip) begin
         bias_eff = bias_mag - (bias_mag >> BIAS_CUT_SHIFT);
      end
      // Widened sum so a large bias cannot wrap into a false operate.
      op_now = {1'b0, diff_mag} > ({1'b0, bias_eff} + {1'b0, PICKUP_LSB});
   end

   // Byte handshakes and command flagging on the way in.
   always_comb begin
      push = tx_valid && s_ff.in_rdy;
      pop = s_ff.out_v && link_ready;
      tx_byte = tx_data;
      if (s_ff.byte_idx == CMD_BYTE && s_ff.trip) begin
         tx_byte = tx_data | ITT_MASK;
      end
   end

   // Next state of the whole block.
   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      nxt_s.arr_v = 1'b0;
      nxt_s.calc_go = 1'b0;

      // Sample clock: eight ticks per power cycle.
      if (s_ff.samp_cnt == SAMPLE_PERIOD - 16'h0001) begin
         nxt_s.samp_cnt = '0;
         nxt_s.tick = 1'b1;
         nxt_s.phase = (s_ff.phase == LAST_PHASE) ? 3'h0 : s_ff.phase + 3'h1;
      end else begin
         nxt_s.samp_cnt = s_ff.samp_cnt + 16'h0001;
      end

      // Per sample trip decision.
      if (nxt_s.tick) begin
         nxt_s.scaled = {adc_data, 1'b0};
         if (op_now) begin
            // Consecutive operate count saturates at the decision count.
            if (s_ff.op_cnt != TRIP_SAMPLES) begin
               nxt_s.op_cnt = s_ff.op_cnt + 3'h1;
            end
         end else begin
            nxt_s.op_cnt = '0;
         end
         nxt_s.detect = nxt_s.op_cnt >= DETECT_SAMPLES;
         if (nxt_s.op_cnt == TRIP_SAMPLES) begin
            nxt_s.trip = 1'b1;
         end else if (!s_ff.rem_acc && !op_now) begin
            nxt_s.trip = 1'b0;
         end
      end

      // Received messages: stamp, start calculation, validate command.
      if (rx_msg_valid) begin
         // Stamp is taken on the next edge, far inside the arrival bound.
         nxt_s.stamp = {s_ff.phase, s_ff.samp_cnt};
         nxt_s.arr_v = 1'b1;
         nxt_s.calc_go = 1'b1;
         if (s_ff.rx_seen && rx_itt == s_ff.rx_prev) begin
            nxt_s.rem_acc = rx_itt;
         end
         nxt_s.rx_prev = rx_itt;
         nxt_s.rx_seen = 1'b1;
      end
      if (nxt_s.rem_acc) begin
         nxt_s.trip = 1'b1;
      end

      // Message byte position, wrapping every message.
      if (push) begin
         nxt_s.byte_idx = (s_ff.byte_idx == LAST_BYTE) ? 5'h00 : s_ff.byte_idx + 5'h01;
      end

      // Pacing: one byte per line byte time, so a slow link backs up the buffer.
      if (pop) begin
         nxt_s.head_v = 1'b0;
         nxt_s.gap = BYTE_PERIOD - 11'h001;
      end else if (s_ff.gap != 11'h000) begin
         nxt_s.gap = s_ff.gap - 11'h001;
      end

      // Two entry buffer: head drives the link, skid catches a stalled word.
      if (!nxt_s.head_v) begin
         if (s_ff.skid_v) begin
            nxt_s.head_v = 1'b1;
            nxt_s.head_d = s_ff.skid_d;
            nxt_s.skid_v = push;
            nxt_s.skid_d = tx_byte;
         end else if (push) begin
            nxt_s.head_v = 1'b1;
            nxt_s.head_d = tx_byte;
         end
      end else if (push) begin
         nxt_s.skid_v = 1'b1;
         nxt_s.skid_d = tx_byte;
      end
      nxt_s.out_v = nxt_s.head_v && nxt_s.gap == 11'h000;
      nxt_s.in_rdy = !nxt_s.skid_v;
   end

   // Single state register.
   always_ff @(posedge clock) begin
      if (rst) begin
         s_ff <= STATE_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register.
   assign sample_tick = s_ff.tick;
   assign scaled_sample = s_ff.scaled;
   assign fault_detect = s_ff.detect;
   assign trip_out = s_ff.trip;
   assign rem_itt_accepted = s_ff.rem_acc;
   assign arrival_valid = s_ff.arr_v;
   assign arrival_stamp = s_ff.stamp;
   assign calc_start = s_ff.calc_go;
   assign tx_ready = s_ff.in_rdy;
   assign link_valid = s_ff.out_v;
   assign link_data = s_ff.head_d;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Checks on the decision and message paths.
   // The command byte lands in the skid entry when the head entry stays full, else in the head entry.
   a_cmd_bit_set: assert property (push && s_ff.byte_idx == CMD_BYTE && s_ff.trip
      |=> (s_ff.skid_v ? s_ff.skid_d[0] : s_ff.head_d[0]))
      else $error("Intertrip bit missing from command byte.");
   a_itt_accept: assert property ($rose(s_ff.rem_acc) |-> $past(rx_msg_valid)
      && $past(rx_itt) && $past(s_ff.rx_prev)) else $error("Intertrip accepted unvalidated.");
   a_trip_hold: assert property ($fell(s_ff.trip) |-> !s_ff.rem_acc && !$past(s_ff.rem_acc))
      else $error("Trip reset while remote intertrip accepted.");
   a_itt_remove: assert property ($fell(s_ff.rem_acc) |-> $past(rx_msg_valid)
      && !$past(rx_itt) && !$past(s_ff.rx_prev)) else $error("Intertrip removal unvalidated.");
   a_byte_wrap: assert property (s_ff.byte_idx == LAST_BYTE && push |=> s_ff.byte_idx == 5'h00)
      else $error("Message byte position did not wrap.");
   a_calc_start: assert property (rx_msg_valid |=> s_ff.calc_go && s_ff.arr_v)
      else $error("Calculation not started after arrival.");
   a_trip_cause: assert property ($rose(s_ff.trip) |-> s_ff.rem_acc
      || s_ff.op_cnt == TRIP_SAMPLES) else $error("Trip without four samples or remote.");
   a_detect_first: assert property ($rose(s_ff.detect) && !s_ff.trip |-> s_ff.op_cnt ==
      DETECT_SAMPLES) else $error("Detection count wrong.");
   a_scale_double: assert property (s_ff.tick |-> s_ff.scaled == {$past(adc_data), 1'b0})
      else $error("Sample not doubled.");
   a_stamp_taken: assert property (rx_msg_valid |=> s_ff.stamp ==
      $past({s_ff.phase, s_ff.samp_cnt})) else $error("Arrival stamp wrong.");
   a_phase_wrap: assert property (s_ff.tick && $past(s_ff.phase) == LAST_PHASE
      |-> s_ff.phase == 3'h0) else $error("Phase did not wrap after eight samples.");
   a_remote_trip: assert property (s_ff.rem_acc |-> s_ff.trip)
      else $error("Accepted remote intertrip without trip.");

   // The tick only comes when the sample counter has just wrapped.
   a_tick_origin: assert property (s_ff.tick |-> s_ff.samp_cnt == 16'h0000)
      else $error("Sample tick away from counter origin.");
   // A tick is one cycle long; this needs a sample period above one cycle.
   a_tick_single: assert property (s_ff.tick |=> !s_ff.tick)
      else $error("Sample tick longer than one cycle.");
   // Phase only advances on a tick.
   a_phase_hold: assert property (!s_ff.tick |-> $stable(s_ff.phase))
      else $error("Phase moved between ticks.");
   // Scaled sample is held from one tick to the next.
   a_scaled_hold: assert property (!s_ff.tick |-> $stable(s_ff.scaled))
      else $error("Scaled sample changed between ticks.");

   // The operate count saturates at the decision count.
   a_count_max: assert property (s_ff.op_cnt <= TRIP_SAMPLES)
      else $error("Operate count beyond decision count.");
   // The operate count moves only on a tick.
   a_count_step: assert property (!s_ff.tick |-> $stable(s_ff.op_cnt))
      else $error("Operate count moved between ticks.");
   // Four consecutive operate samples always trip.
   a_trip_four: assert property (s_ff.tick && s_ff.op_cnt == TRIP_SAMPLES |-> s_ff.trip)
      else $error("Four operate samples without trip.");
   // Fault detection only changes on a tick.
   a_detect_step: assert property (!s_ff.tick |-> $stable(s_ff.detect))
      else $error("Fault detection moved between ticks.");
   // A local trip is preceded by a detected fault.
   a_trip_after_detect: assert property ($rose(s_ff.trip) && !s_ff.rem_acc
      |-> $past(s_ff.detect))
      else $error("Trip without earlier fault detection.");
   // Trip resets only on a quiet sample.
   a_trip_clear_quiet: assert property ($fell(s_ff.trip)
      |-> s_ff.tick && s_ff.op_cnt == 3'h0)
      else $error("Trip reset off a quiet sample.");
   // Trip changes only on a tick or through an accepted remote command.
   a_trip_out_tick: assert property ($changed(s_ff.trip) |-> s_ff.tick || s_ff.rem_acc)
      else $error("Trip changed outside a tick without remote command.");

   // Without a trip the restraint is used unchanged.
   a_bias_plain: assert property (!s_ff.trip |-> bias_eff == bias_mag)
      else $error("Restraint cut while not tripped.");
   // With a trip any restraint of four counts or more is reduced.
   a_bias_cut: assert property (s_ff.trip && bias_mag >= 13'h0004
      |-> bias_eff < bias_mag)
      else $error("Restraint not reduced after trip.");
   // Operate never happens at or below the pickup level.
   a_pickup_floor: assert property (op_now |-> diff_mag > PICKUP_LSB)
      else $error("Operate below the pickup level.");

   // No acceptance before any message has been seen.
   a_first_msg: assert property (!s_ff.rx_seen |-> !s_ff.rem_acc)
      else $error("Intertrip accepted without a predecessor.");
   // Acceptance changes only on a received message.
   a_accept_quiet: assert property (!$past(rx_msg_valid) |-> $stable(s_ff.rem_acc))
      else $error("Intertrip acceptance changed without a message.");
   // Arrival pulses only follow a received message.
   a_arrival_pulse: assert property (!$past(rx_msg_valid) |-> !s_ff.arr_v)
      else $error("Arrival pulse without a message.");
   // Calculation start only follows a received message.
   a_calc_pulse: assert property (!$past(rx_msg_valid) |-> !s_ff.calc_go)
      else $error("Calculation start without a message.");
   // The stamp counter part lies inside one sample period.
   a_stamp_range: assert property (s_ff.arr_v |-> s_ff.stamp[15:0] < SAMPLE_PERIOD)
      else $error("Arrival stamp outside the sample period.");
   // The stamp stands until the next arrival.
   a_stamp_hold: assert property (!s_ff.arr_v |-> $stable(s_ff.stamp))
      else $error("Arrival stamp changed without arrival.");

   // A refused byte stays on the link unchanged.
   a_link_hold: assert property (s_ff.out_v && !link_ready
      |=> s_ff.out_v && $stable(s_ff.head_d))
      else $error("Link byte dropped or changed while stalled.");
   // After a byte is taken the link waits a byte time; needs a byte period above one.
   a_link_gap: assert property (pop |=> !s_ff.out_v)
      else $error("Link byte sent without pacing gap.");
   // A full buffer refuses the framer.
   a_ready_full: assert property (s_ff.skid_v |-> !s_ff.in_rdy)
      else $error("Framer accepted into a full buffer.");
   // The skid entry is only used behind a valid head.
   a_skid_order: assert property (s_ff.skid_v |-> s_ff.head_v)
      else $error("Skid entry valid with empty head.");
   // Byte position stays inside one message.
   a_idx_range: assert property (s_ff.byte_idx <= LAST_BYTE)
      else $error("Byte position beyond message length.");

   // Main scenarios.
   c_local_trip: cover property ($rose(s_ff.trip) && !s_ff.rem_acc);
   c_itt_removed: cover property ($fell(s_ff.rem_acc));
   c_remote_trip: cover property ($rose(s_ff.rem_acc));
   c_buffer_full: cover property (s_ff.head_v && s_ff.skid_v && !link_ready);
   c_trip_reset: cover property ($fell(s_ff.trip));

endmodule : dti_core

// [dv/far_link.sv]
// Far-end channel model that takes paced message bytes and keeps them.
`timescale 1ns/100ps
module far_link (
   // Clock.
   input wire logic clock,
   // Byte stream from the block.
   input wire logic link_valid,
   input wire logic [7:0] link_data,
   output logic link_ready,
   // Pace choice.
   input wire logic slow
);
   logic [7:0] got [0:41];
   int got_n = 0;
   logic [1:0] pace = 2'h0;
   // A slow end stalls three cycles in four, so the buffer must hold bytes.
   assign link_ready = !slow || pace == 2'h0;
   // Each byte taken is stored until the 42 entries are full; two whole 21-byte messages fit.
   always @(posedge clock) begin
      pace <= pace + 2'h1;
      if (link_valid && link_ready && got_n < 42) begin
         got[got_n] <= link_data;
         got_n <= got_n + 1;
      end
   end
endmodule : far_link

// [dv/tb_differential_trip_intertrip_logic.sv]
// Self-checking bench for the trip decision and intertrip block.
`timescale 1ns/100ps
module tb_differential_trip_intertrip_logic import dti_pkg::*;;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [ADC_W-1:0] adc_data = '0;
   logic [DATA_W-1:0] diff_mag = '0, bias_mag = '0, scaled_sample;
   logic rx_msg_valid = 1'b0, rx_itt = 1'b0, tx_valid = 1'b0, slow = 1'b0;
   logic [7:0] tx_data = '0, link_data;
   logic sample_tick, fault_detect, trip_out, rem_itt_accepted;
   logic arrival_valid, calc_start, tx_ready, link_valid, link_ready;
   logic [18:0] arrival_stamp;
   int errors = 0, compares = 0, cycles = 0, refused = 0;

   // Short counts keep the run brief; the tick and frame wait limits of the bench rely on them.
   dti_core #(.SAMPLE_PERIOD(16'h0014), .BYTE_PERIOD(11'h004)) uut (
      .clock(clock), .rst(rst), .adc_data(adc_data), .diff_mag(diff_mag),
      .bias_mag(bias_mag), .sample_tick(sample_tick), .scaled_sample(scaled_sample),
      .fault_detect(fault_detect), .trip_out(trip_out), .rx_msg_valid(rx_msg_valid),
      .rx_itt(rx_itt), .rem_itt_accepted(rem_itt_accepted),
      .arrival_valid(arrival_valid), .arrival_stamp(arrival_stamp),
      .calc_start(calc_start), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .link_valid(link_valid), .link_data(link_data),
      .link_ready(link_ready));
   far_link far (.clock(clock), .link_valid(link_valid), .link_data(link_data),
      .link_ready(link_ready), .slow(slow));

   // Free-running 100 ns clock.
   initial begin
      forever #50 clock = ~clock;
   end

   // A hang is cut short well past the expected run length.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors = errors + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // Inputs always move 10 ns after the rising edge, where outputs are settled.
   task automatic step();
      @(posedge clock);
      #10;
   endtask : step

   task automatic wait_tick();
      int n = 0;
      do begin
         step();
         n++;
      end while (sample_tick !== 1'b1 && n < 100);
   endtask : wait_tick

   task automatic send_msg(input logic itt);
      rx_msg_valid = 1'b1;
      rx_itt = itt;
      step();
      rx_msg_valid = 1'b0;
      chk(arrival_valid, 1);
      chk(calc_start, 1);
      step();
   endtask : send_msg

   // One whole message through the buffer while the far end stalls.
   task automatic send_frame(input logic tripped);
      int base = far.got_n;
      slow = 1'b1;
      for (int i = 0; i < MSG_BYTES; i++) begin
         tx_valid = 1'b1;
         tx_data = 8'hA0 + 8'(2 * i);
         while (tx_ready !== 1'b1) begin
            step();
            refused++;
         end
         step();
      end
      tx_valid = 1'b0;
      repeat (300) if (far.got_n < base + MSG_BYTES) step();
      for (int i = 0; i < MSG_BYTES; i++) begin
         chk(far.got[base + i], (8'hA0 + 8'(2 * i)) | 8'(i == 1 && tripped));
      end
      chk(refused > 0, 1);
   endtask : send_frame

   // Main sequence: framing, scaling, trip count, hysteresis, remote command.
   initial begin
      repeat (4) @(posedge clock);
      #10;
      rst = 1'b0;
      step();
      send_frame(1'b0);
      adc_data = 12'h044;
      bias_mag = 13'h0190;
      diff_mag = 13'h01AB;
      wait_tick();
      chk(scaled_sample, 13'h0088);
      chk(fault_detect, 0);
      bias_mag = '0;
      for (int k = 1; k <= 8; k++) begin
         diff_mag = (k == 4) ? 13'h001B : 13'h001C;
         wait_tick();
         chk(fault_detect, k inside {2, 3, 6, 7, 8});
         chk(trip_out, k == 8);
      end
      send_frame(1'b1);
      bias_mag = 13'h0190;
      diff_mag = 13'h0148;
      wait_tick();
      chk(trip_out, 1);
      diff_mag = 13'h0147;
      wait_tick();
      chk(trip_out, 0);
      diff_mag = '0;
      send_msg(1'b0);
      send_msg(1'b0);
      send_msg(1'b1);
      chk(rem_itt_accepted, 0);
      send_msg(1'b1);
      chk(rem_itt_accepted, 1);
      chk(trip_out, 1);
      wait_tick();
      chk(trip_out, 1);
      send_msg(1'b0);
      chk(rem_itt_accepted, 1);
      send_msg(1'b0);
      chk(rem_itt_accepted, 0);
      wait_tick();
      chk(trip_out, 0);
      print_verdict();
   end
endmodule : tb_differential_trip_intertrip_logic
